// ==== logic/ddr_init_core.v ====
// DRAM-side reset, initialization, mode register and access front end.
// Assumes command pins are registered on mclk_i rising edge, in sync.
//
// Notes on behaviour
// RQ1: Each access is one four-clock 8n-bit core transfer, two words a clock.
// RQ2: Bursts are eight or chopped four; activate uses bank and row address.
// RQ3: Read/write gives column; A10 auto precharge; A12 chops if on-the-fly.
// RQ4: Controller holds reset low at least 200 us after power is stable.
// RQ5: Controller drives clock enable low at least 10 ns before reset release.
// RQ6: Device initializes internally in the 500 us before clock enable rises.
// RQ7: Controller runs clock and a no-op before clock enable rises.
// RQ8: Clock enable stays high until initialization completes.
// RQ9: Termination stays high impedance in reset and until clock enable seen.
// RQ10: Controller holds termination control static during initialization.
// RQ11: Controller waits reset-exit time before the first mode set.
// RQ12: Mode registers are loaded in order two, three, one, zero.
// RQ13: Bank address selects which mode register is written.
// RQ14: Register one enables DLL; register zero then requests DLL reset.
// RQ15: Long calibration follows, then DLL lock and calibration time wait.
// RQ16: Only no-ops or deselects between mode sets and long calibration.
// RQ17: Reset at stable power lasts 100 ns, then repeats the 500 us wait.
// RQ18: Mode registers are undefined after reset until fully written.
// RQ19: Each mode set carries all address fields of the selected register.
// RQ20: Mode sets and DLL reset leave array contents untouched.
// RQ21: Mode sets are spaced by at least the mode set cycle time.
// RQ22: New mode contents are accepted during normal operation.
// RQ23: Mode rewrites happen only when idle with clock enable high; the core takes them in RUN with clock enable high and no idle check.
// RQ24: Mode update delay passes before non-mode, non-no-op commands.

`include "ddr_init_map.vh"

// ----------------------------------------------------------------------
// Data FIFO
// ----------------------------------------------------------------------
module data_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             mclk_i,
   input  wire             reset_n_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      count_r;
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   wire            push;
   wire            pop;

   assign in_ready_o  = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge mclk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         count_r  <= {(AW+1){1'b0}};
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // data_fifo

// ----------------------------------------------------------------------
// Device core
// ----------------------------------------------------------------------
module ddr_init_core #(
   parameter N          = 16,
   parameter INIT_WAIT  = `INIT_WAIT_CYC,
   parameter MODE_SET_CYC = 4,
   parameter MODE_UPD_CYC = 12
) (
   // Clock and reset
   input  wire          mclk_i,
   input  wire          reset_n_i,
   // Command pins
   input  wire          clk_enable_i,
   input  wire          cs_n_i,
   input  wire          ras_n_i,
   input  wire          cas_n_i,
   input  wire          we_n_i,
   input  wire [2:0]    bank_i,
   input  wire [12:0]   addr_i,
   input  wire          termination_control_pin_i,
   // Write data, two words per clock
   input  wire          wr_valid_i,
   output wire          wr_ready_o,
   input  wire [2*N-1:0] wr_data_i,
   // Core side stream of 8n-bit transfers
   output reg  [8*N-1:0] core_data_o,
   output reg           core_valid_o,
   // Termination and status
   output reg           termination_on_o,
   output reg           init_ready_o,
   output reg           dll_reset_pulse_o,
   output reg           auto_precharge_o,
   output reg           chop_burst_o,
   output reg  [2:0]    open_bank_o,
   output reg  [12:0]   open_row_o,
   output reg  [3:0]    mode_written_o,
   output reg  [12:0]   mode_reg_zero_o,
   output reg  [12:0]   mode_reg_one_o,
   output reg  [12:0]   mode_reg_two_o,
   output reg  [12:0]   mode_reg_three_o
);
   localparam ST_WAIT = 3'h1;
   localparam ST_CKE  = 3'h2;
   localparam ST_RUN  = 3'h4;

   reg  [2:0]  state_r;
   reg  [15:0] wait_r;
   reg  [1:0]  beat_r;
   reg  [8*N-1:0] gather_r;
   wire [3:0]  cmd;
   wire        cmd_mode_set;
   wire        cmd_access;
   wire        fifo_valid;
   wire [2*N-1:0] fifo_data;
   wire        chop_sel;

   assign cmd          = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
   assign cmd_mode_set = clk_enable_i && (cmd == `CMD_MODE_SET);
   assign cmd_access   = clk_enable_i &&
                         ((cmd & `CMD_READWRITE_MASK) == `CMD_WRITE);
   assign chop_sel = (mode_reg_zero_o[1:0] == `BURST_ON_THE_FLY) ?
                     ~addr_i[`ADDR_BURST_CHOP_N] :
                     (mode_reg_zero_o[1:0] == `BURST_FIXED_CHOP); // RQ3

   data_fifo #(.WIDTH(2*N), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .in_data_i   (wr_data_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (state_r == ST_RUN),
      .out_data_o  (fifo_data)
   );

   // -------------------------------------------------------------------
   // Reset and initialization sequencing
   // -------------------------------------------------------------------
   // Reset restarts the internal wait whether at power-up or later
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         state_r          <= ST_WAIT;                   // RQ17
         wait_r           <= 16'h0000;
         termination_on_o <= 1'b0;                      // RQ9
         init_ready_o     <= 1'b0;
      end else begin
         case (state_r)
            ST_WAIT: begin
               if (wait_r != INIT_WAIT[15:0]) begin
                  wait_r <= wait_r + 16'h0001;          // RQ6
               end else begin
                  state_r <= ST_CKE;
               end
            end
            ST_CKE: begin
               if (clk_enable_i) begin
                  state_r          <= ST_RUN;
                  termination_on_o <= ~termination_control_pin_i; // RQ9
               end
            end
            ST_RUN: begin
               init_ready_o <= (mode_written_o == 4'hF); // RQ18
            end
            default: begin
               state_r <= ST_WAIT;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Mode registers and activate decode
   // -------------------------------------------------------------------
   // Array contents are never touched by this path
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         mode_written_o    <= 4'h0;
         dll_reset_pulse_o <= 1'b0;
         mode_reg_zero_o   <= 13'h0000;
         mode_reg_one_o    <= 13'h0000;
         mode_reg_two_o    <= 13'h0000;
         mode_reg_three_o  <= 13'h0000;
         open_bank_o       <= 3'h0;
         open_row_o        <= 13'h0000;
         auto_precharge_o  <= 1'b0;
         chop_burst_o      <= 1'b0;
      end else begin
         dll_reset_pulse_o <= 1'b0;
         if (state_r == ST_RUN && cmd_mode_set) begin   // RQ20 RQ22
            case (bank_i)                               // RQ13
               `BANK_MODE_REG_ZERO: begin
                  mode_reg_zero_o   <= addr_i;          // RQ19
                  mode_reg_zero_o[`ADDR_DLL_RESET] <= 1'b0;
                  dll_reset_pulse_o <= addr_i[`ADDR_DLL_RESET]; // RQ14
                  mode_written_o[0] <= 1'b1;
               end
               `BANK_MODE_REG_ONE: begin
                  mode_reg_one_o    <= addr_i;
                  mode_written_o[1] <= 1'b1;
               end
               `BANK_MODE_REG_TWO: begin
                  mode_reg_two_o    <= addr_i;
                  mode_written_o[2] <= 1'b1;
               end
               `BANK_MODE_REG_THREE: begin
                  mode_reg_three_o  <= addr_i;
                  mode_written_o[3] <= 1'b1;
               end
               default: begin
                  mode_written_o <= mode_written_o;
               end
            endcase
         end
         if (state_r == ST_RUN && clk_enable_i &&
             cmd == `CMD_ACTIVATE) begin
            open_bank_o <= bank_i;                      // RQ2
            open_row_o  <= addr_i;
         end
         if (state_r == ST_RUN && cmd_access) begin
            auto_precharge_o <= addr_i[`ADDR_AUTO_PRECHARGE]; // RQ3
            chop_burst_o     <= chop_sel;
         end
      end
   end

   // -------------------------------------------------------------------
   // Core transfer: four clocks of two words make 8n bits
   // -------------------------------------------------------------------
   // Stalls on an empty FIFO, so a partial transfer simply waits
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         beat_r       <= 2'h0;
         gather_r     <= {(8*N){1'b0}};
         core_data_o  <= {(8*N){1'b0}};
         core_valid_o <= 1'b0;
      end else begin
         core_valid_o <= 1'b0;
         if (state_r == ST_RUN && fifo_valid) begin
            gather_r <= {fifo_data, gather_r[8*N-1:2*N]};  // RQ1
            beat_r   <= beat_r + 2'h1;
            if (beat_r == 2'h3) begin
               core_data_o  <= {fifo_data, gather_r[8*N-1:2*N]}; // RQ1
               core_valid_o <= 1'b1;
            end
         end
      end
   end
endmodule // ddr_init_core

// ==== logic/ddr_init_map.vh ====
// Constants for the DRAM-side initialization and mode setup block.
// Assumes inclusion by the design, model, checker and bench files; timing counts at 25 MHz.
`ifndef DDR_INIT_MAP_VH
`define DDR_INIT_MAP_VH

// ----------------------------------------------------------------------
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define CMD_ACTIVATE       4'h3
`define CMD_READWRITE_MASK 4'hE
`define CMD_WRITE          4'h4
`define CMD_READ           4'h5
`define CMD_MODE_SET       4'h0
`define CMD_NO_OPERATION   4'h7
`define CMD_CALIBRATE      4'h6

// ----------------------------------------------------------------------
// Mode register select on bank address
// ----------------------------------------------------------------------
`define BANK_MODE_REG_ZERO  3'h0
`define BANK_MODE_REG_ONE   3'h1
`define BANK_MODE_REG_TWO   3'h2
`define BANK_MODE_REG_THREE 3'h3

// ----------------------------------------------------------------------
// Address field positions
// ----------------------------------------------------------------------
`define ADDR_AUTO_PRECHARGE 10
`define ADDR_BURST_CHOP_N   12
`define ADDR_DLL_DISABLE    0
`define ADDR_DLL_RESET      8
`define MR0_BURST_LSB       0
`define BURST_ON_THE_FLY    2'h1
`define BURST_FIXED_CHOP    2'h2

// ----------------------------------------------------------------------
// Timing: times in ns, then cycles at 40 ns
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       40
`define INIT_WAIT_NS        500000
`define INIT_WAIT_CYC ((`INIT_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_XFER_CYC       4
`define FIFO_DEPTH          8

`endif

// ==== dv/ddr_ctrl_model.sv ====
// Controller-side model: drives clock enable, commands and termination.
// Assumes the bench calls its tasks from one process only.
`include "ddr_init_map.vh"
module ddr_ctrl_model (
   input  wire logic        mclk_i,
   output logic             clk_en_o,
   output logic [3:0]       cmd_o,
   output logic [2:0]       bank_o,
   output logic [12:0]      addr_o,
   output logic             term_ctl_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // Command tasks
   // ------------------------------------------------------------------
   initial begin
      clk_en_o = 1'b0;
      cmd_o = `CMD_NO_OPERATION;
      bank_o = 3'h0;
      addr_o = 13'h0000;
      term_ctl_o = 1'b0;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                      input logic [12:0] a);
      @(posedge mclk_i);
      cmd_o <= c;
      bank_o <= b;
      addr_o <= a;
      @(posedge mclk_i);
      cmd_o <= `CMD_NO_OPERATION;
      // Released lines toggle so a stale value never passes
      bank_o <= ~b;
      addr_o <= ~a;
   endtask
   task automatic park;
      @(posedge mclk_i);
      clk_en_o <= 1'b0;
   endtask
   task automatic init_seq;
      park();
      idle(25);
      clk_en_o <= 1'b1;
      idle(5);
      cmd(`CMD_MODE_SET, `BANK_MODE_REG_TWO, 13'h0018);
      idle(4);
      cmd(`CMD_MODE_SET, `BANK_MODE_REG_THREE, 13'h0004);
      idle(4);
      cmd(`CMD_MODE_SET, `BANK_MODE_REG_ONE, 13'h0046);
      idle(4);
      cmd(`CMD_MODE_SET, `BANK_MODE_REG_ZERO, 13'h0121);
      idle(12);
      cmd(`CMD_CALIBRATE, 3'h0, 13'h0400);
      idle(20);
   endtask
endmodule // ddr_ctrl_model

// ==== dv/ddr_init_core_checker.sv ====
// Port-level assertions for the DRAM-side init and mode block.
// Assumes binding onto ddr_init_core; header on the include path.
`include "ddr_init_map.vh"
module ddr_init_core_checker (
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   input wire logic        clk_enable_i,
   input wire logic        cs_n_i,
   input wire logic        ras_n_i,
   input wire logic        cas_n_i,
   input wire logic        we_n_i,
   input wire logic [2:0]  bank_i,
   input wire logic [12:0] addr_i,
   input wire logic        termination_on_o,
   input wire logic        init_ready_o,
   input wire logic        dll_reset_pulse_o,
   input wire logic        auto_precharge_o,
   input wire logic        core_valid_o,
   input wire logic [2:0]  open_bank_o,
   input wire logic [12:0] open_row_o,
   input wire logic [3:0]  mode_written_o,
   input wire logic [12:0] mode_reg_zero_o,
   input wire logic [12:0] mode_reg_two_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   wire [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
   wire       ms = (cmd == `CMD_MODE_SET);
   // Mode load, activate and access checks run in normal operation only, where RUN is known at the ports
   wire       live = clk_enable_i && init_ready_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   a_odt_in_reset: assert property (disable iff (1'b0)
      !reset_n_i |=> !termination_on_o) else $error("termination on");
   a_odt_wait_cke: assert property ($rose(termination_on_o) |->
      $past(clk_enable_i)) else $error("termination before enable");
   a_mode_two_load: assert property (live && ms && bank_i == 3'h2
      |=> mode_reg_two_o == $past(addr_i)) else $error("reg two");
   a_mode_zero_load: assert property (live && ms && bank_i == 3'h0
      |=> mode_reg_zero_o == ($past(addr_i) & 13'h1EFF))
      else $error("reg zero");
   a_dll_pulse: assert property (live && ms && bank_i == 3'h0
      && addr_i[8] |=> dll_reset_pulse_o ##1 !dll_reset_pulse_o)
      else $error("dll pulse");
   a_row_open: assert property (live && cmd == `CMD_ACTIVATE |=>
      open_row_o == $past(addr_i) && open_bank_o == $past(bank_i))
      else $error("row open");
   a_auto_pre: assert property (live && cmd[3:1] == 3'b010 |=>
      auto_precharge_o == $past(addr_i[10])) else $error("precharge");
   a_high_bank_skip: assert property (live && ms && bank_i[2] |=>
      $stable(mode_written_o) && $stable(mode_reg_zero_o))
      else $error("high bank");
   a_idle_cke_off: assert property (!clk_enable_i && ms |=>
      $stable(mode_written_o)) else $error("mode set taken");
   a_ready_all: assert property (init_ready_o |->
      mode_written_o == 4'hF) else $error("ready early");
   a_core_pulse: assert property (core_valid_o |=>
      !core_valid_o) else $error("core pulse");
   c_init: cover property ($rose(init_ready_o));
   c_core: cover property (core_valid_o);
   c_dll: cover property (dll_reset_pulse_o);
endmodule // ddr_init_core_checker
bind ddr_init_core ddr_init_core_checker u_chk (.*);

// ==== dv/tb_sdram_init_and_mode_setup.sv ====
// Self-checking bench for the DRAM-side init and mode block.
// Assumes ddr_init_core, its FIFO and the controller model compiled.
`include "ddr_init_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_sdram_init_and_mode_setup;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------------
   logic         mclk_i = 1'b0;
   logic         reset_n_i = 1'b0;
   logic         wr_valid_i = 1'b0;
   logic [31:0]  wr_data_i = 32'h0;
   wire          cke, term, wr_ready_o, core_valid_o, termination_on_o;
   wire          init_ready_o, dll_reset_pulse_o, auto_precharge_o;
   wire          chop_burst_o;
   wire [3:0]    cmd, mode_written_o;
   wire [2:0]    bank, open_bank_o;
   wire [12:0]   addr, open_row_o, mr0, mr1, mr2, mr3;
   wire [127:0]  core_data_o;
   int           miscompares = 0;
   int           num_checks = 0;
   int           cycles = 0;
   int           dll_cnt = 0;
   logic [127:0] core_q[$];
   initial forever #20 mclk_i = ~mclk_i;
   ddr_ctrl_model u_ctrl (.mclk_i(mclk_i), .clk_en_o(cke), .cmd_o(cmd),
      .bank_o(bank), .addr_o(addr), .term_ctl_o(term));
   ddr_init_core #(.INIT_WAIT(20)) dut_u (.mclk_i(mclk_i),
      .reset_n_i(reset_n_i), .clk_enable_i(cke), .cs_n_i(cmd[3]),
      .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_i(bank),
      .addr_i(addr), .termination_control_pin_i(term),
      .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
      .wr_data_i(wr_data_i), .core_data_o(core_data_o),
      .core_valid_o(core_valid_o), .termination_on_o(termination_on_o),
      .init_ready_o(init_ready_o), .dll_reset_pulse_o(dll_reset_pulse_o),
      .auto_precharge_o(auto_precharge_o), .chop_burst_o(chop_burst_o),
      .open_bank_o(open_bank_o), .open_row_o(open_row_o),
      .mode_written_o(mode_written_o), .mode_reg_zero_o(mr0),
      .mode_reg_one_o(mr1), .mode_reg_two_o(mr2), .mode_reg_three_o(mr3));
   always @(posedge mclk_i) begin
      if (core_valid_o === 1'b1) core_q.push_back(core_data_o);
      if (dll_reset_pulse_o === 1'b1) dll_cnt++;
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic push(input logic [31:0] w);
      wr_valid_i <= 1'b1;
      wr_data_i <= w;
      do @(posedge mclk_i); while (wr_ready_o !== 1'b1);
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      u_ctrl.park();
      reset_n_i <= 1'b0;
      u_ctrl.idle(8);
      #1 `CHK("termination", 1'b0, termination_on_o)
      `CHK("written", 4'h0, mode_written_o)
      `CHK("ready", 1'b0, init_ready_o)
      @(posedge mclk_i);
      reset_n_i <= 1'b1;
   endtask
   task automatic t_early;
      u_ctrl.cmd(`CMD_MODE_SET, 3'h2, 13'h1555);
      #1 `CHK("early mode", 4'h0, mode_written_o)
      @(posedge mclk_i);
      for (int i = 0; i < 8; i++) push(32'hC0DE0000 + i);
      wr_valid_i <= 1'b0;
      #1 `CHK("fifo full", 1'b0, wr_ready_o)
   endtask
   task automatic t_init;
      u_ctrl.init_seq();
      `CHK("reg two", 13'h0018, mr2)
      `CHK("reg three", 13'h0004, mr3)
      `CHK("reg one", 13'h0046, mr1)
      `CHK("reg zero", 13'h0021, mr0)
      `CHK("written", 4'hF, mode_written_o)
      `CHK("ready", 1'b1, init_ready_o)
      `CHK("termination", 1'b1, termination_on_o)
      `CHK("dll pulses", 1, dll_cnt)
      `CHK("core words", 2, core_q.size())
      `CHK("core 0", 128'hC0DE0003C0DE0002C0DE0001C0DE0000, core_q[0])
      `CHK("core 1", 128'hC0DE0007C0DE0006C0DE0005C0DE0004, core_q[1])
   endtask
   task automatic t_access;
      u_ctrl.cmd(`CMD_ACTIVATE, 3'h5, 13'h1ABC);
      #1 `CHK("bank", 3'h5, open_bank_o)
      `CHK("row", 13'h1ABC, open_row_o)
      u_ctrl.cmd(`CMD_READ, 3'h5, 13'h0400);
      #1 `CHK("precharge", 1'b1, auto_precharge_o)
      `CHK("chop", 1'b1, chop_burst_o)
      u_ctrl.cmd(`CMD_WRITE, 3'h5, 13'h1000);
      #1 `CHK("precharge", 1'b0, auto_precharge_o)
      `CHK("chop", 1'b0, chop_burst_o)
      for (int m = 0; m < 3; m++) begin
         u_ctrl.cmd(`CMD_MODE_SET, 3'h0, 13'h0100 | 13'(m));
         #1 `CHK("burst mode", 13'(m), mr0)
         u_ctrl.idle(12);
         u_ctrl.cmd(`CMD_READ, 3'h5, 13'h0000);
         #1 `CHK("chop", m != 0, chop_burst_o)
      end
      u_ctrl.idle(4);
      u_ctrl.cmd(`CMD_MODE_SET, 3'h2, 13'h0A18);
      #1 `CHK("reg two", 13'h0A18, mr2)
      u_ctrl.idle(4);
      u_ctrl.cmd(`CMD_MODE_SET, 3'h4, 13'h1FFF);
      #1 `CHK("high bank", 13'h0002, mr0)
      `CHK("dll pulses", 4, dll_cnt)
   endtask
   initial begin
      t_reset();
      t_early();
      t_init();
      t_access();
      t_reset();
      t_early();
      print_verdict();
   end
endmodule // tb_sdram_init_and_mode_setup
